// file: hw/hfbt_pkg.sv
// Shared constants for the freewheel, magnetic and touch tuning register bank.
// Assumes a byte-wide register index and 16-bit register words.
`default_nettype none

package hfbt_pkg;

    // ----------------------------------------------------------------
    // Register geometry
    // ----------------------------------------------------------------
    localparam int          HFBT_NREG  = 12;       // Registers in the bank.
    localparam int          HFBT_AW    = 8;        // Register index width.
    localparam int          HFBT_DW    = 16;       // Register word width.
    localparam int          HFBT_BYTE_W = 8;       // Width of one byte field.

    // ----------------------------------------------------------------
    // Register indexes, in bank order
    // ----------------------------------------------------------------
    localparam logic [7:0] HFBT_OFS_PLATE_BIAS_LO   = 8'h82;
    localparam logic [7:0] HFBT_OFS_PLATE_BIAS_HI   = 8'h83;
    localparam logic [7:0] HFBT_OFS_PLATE_OFS_LO    = 8'h84;
    localparam logic [7:0] HFBT_OFS_PLATE_OFS_HI    = 8'h85;
    localparam logic [7:0] HFBT_OFS_SCROLL_COEFFS   = 8'h90;
    localparam logic [7:0] HFBT_OFS_SCROLL_THR      = 8'h98;
    localparam logic [7:0] HFBT_OFS_SCROLL_REV_THR  = 8'h99;
    localparam logic [7:0] HFBT_OFS_MAG_TUNING      = 8'ha2;
    localparam logic [7:0] HFBT_OFS_TOUCH_COEFFS    = 8'hb4;
    localparam logic [7:0] HFBT_OFS_TOUCH_AVG       = 8'hb5;
    localparam logic [7:0] HFBT_OFS_TOUCH_FAST_AVG  = 8'hb6;
    localparam logic [7:0] HFBT_OFS_TOUCH_RESEED    = 8'hb7;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] HFBT_RST_PLATE_BIAS  = 16'hdbdb;
    localparam logic [15:0] HFBT_RST_PLATE_OFS   = 16'h0000;
    localparam logic [15:0] HFBT_RST_SCROLL_COEF = 16'h0204;
    localparam logic [15:0] HFBT_RST_SCROLL_THR  = 16'h1414;
    localparam logic [15:0] HFBT_RST_SCROLL_REV  = 16'h0014;
    localparam logic [15:0] HFBT_RST_MAG_TUNING  = 16'h0203;
    localparam logic [15:0] HFBT_RST_TOUCH_COEF  = 16'h0102;
    localparam logic [15:0] HFBT_RST_TOUCH_AVG   = 16'h0708;
    localparam logic [15:0] HFBT_RST_TOUCH_FAST  = 16'h0304;
    localparam logic [15:0] HFBT_RST_TOUCH_RESEED = 16'h1005;

    // ----------------------------------------------------------------
    // Writable bit masks; zero bits are reserved or command bits
    // ----------------------------------------------------------------
    localparam logic [15:0] HFBT_WM_FULL    = 16'hffff;
    localparam logic [15:0] HFBT_WM_LOW     = 16'h00ff;
    localparam logic [15:0] HFBT_WM_RESEED  = 16'hfeff;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int HFBT_LO_LSB      = 0;   // Lower byte field.
    localparam int HFBT_HI_LSB      = 8;   // Upper byte field.
    localparam int HFBT_RESEED_BIT  = 8;   // Self-clearing reseed command.
    localparam int HFBT_BAND_LSB    = 9;   // Touch band fraction field.
    localparam int HFBT_BAND_W      = 7;   // Touch band fraction width.

    // ----------------------------------------------------------------
    // Per-register tables, indexed in bank order
    // ----------------------------------------------------------------
    localparam logic [7:0] HFBT_OFS [HFBT_NREG] = '{
        HFBT_OFS_PLATE_BIAS_LO, HFBT_OFS_PLATE_BIAS_HI, HFBT_OFS_PLATE_OFS_LO,
        HFBT_OFS_PLATE_OFS_HI, HFBT_OFS_SCROLL_COEFFS, HFBT_OFS_SCROLL_THR,
        HFBT_OFS_SCROLL_REV_THR, HFBT_OFS_MAG_TUNING, HFBT_OFS_TOUCH_COEFFS,
        HFBT_OFS_TOUCH_AVG, HFBT_OFS_TOUCH_FAST_AVG, HFBT_OFS_TOUCH_RESEED};
    localparam logic [15:0] HFBT_RST [HFBT_NREG] = '{
        HFBT_RST_PLATE_BIAS, HFBT_RST_PLATE_BIAS, HFBT_RST_PLATE_OFS,
        HFBT_RST_PLATE_OFS, HFBT_RST_SCROLL_COEF, HFBT_RST_SCROLL_THR,
        HFBT_RST_SCROLL_REV, HFBT_RST_MAG_TUNING, HFBT_RST_TOUCH_COEF,
        HFBT_RST_TOUCH_AVG, HFBT_RST_TOUCH_FAST, HFBT_RST_TOUCH_RESEED};
    localparam logic [15:0] HFBT_WM [HFBT_NREG] = '{
        HFBT_WM_FULL, HFBT_WM_FULL, HFBT_WM_FULL, HFBT_WM_FULL,
        HFBT_WM_FULL, HFBT_WM_FULL, HFBT_WM_LOW, HFBT_WM_LOW,
        HFBT_WM_FULL, HFBT_WM_FULL, HFBT_WM_FULL, HFBT_WM_RESEED};
    localparam int HFBT_IDX_RESEED = 11;   // Bank slot of the reseed register.

endpackage : hfbt_pkg

`default_nettype wire

// file: hw/hfbt_field_reg.sv
// One 16-bit configuration word with a reset value and a writable-bit mask.
// Assumes the write strobe is already decoded to this word.
`default_nettype none

module hfbt_field_reg
    import hfbt_pkg::*;
#(
    parameter logic [15:0] RST_VAL = 16'h0000,   // Value after reset.
    parameter logic [15:0] WR_MASK = 16'hffff    // Bits that software may change.
) (
    input  wire logic        clk_sys_i,   // System clock.
    input  wire logic        rstn_i,      // Asynchronous reset, active low.
    input  wire logic        wr_i,        // Write strobe for this word.
    input  wire logic [15:0] wdata_i,     // Write data.
    output logic      [15:0] q_o          // Stored word.
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] val;   // Stored word.
    } hfbt_field_state_t;

    hfbt_field_state_t st_q;   // Registered state.
    hfbt_field_state_t st_d;   // Next state.

    // Merge the written bits; masked bits keep their reset value forever.
    always_comb begin
        st_d = st_q;
        if (wr_i) begin
            st_d.val = (wdata_i & WR_MASK) | (st_q.val & ~WR_MASK);
        end
    end

    // Register the state.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q.val <= RST_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.val;

endmodule // hfbt_field_reg

`default_nettype wire

// file: hw/hfbt_cmd_bit.sv
// Self-clearing command bit: a set request raises the bit and a pulse.
// Assumes the consumer acts on the one-cycle pulse.
`default_nettype none

module hfbt_cmd_bit
    import hfbt_pkg::*;
(
    input  wire logic clk_sys_i,   // System clock.
    input  wire logic rstn_i,      // Asynchronous reset, active low.
    input  wire logic set_i,       // Request to issue the command.
    output logic      bit_o,       // Command bit as software reads it.
    output logic      pulse_o      // One-cycle command pulse.
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic busy;    // Command bit still shown as set.
        logic pulse;   // Command pulse to the engine.
    } hfbt_cmd_state_t;

    hfbt_cmd_state_t st_q;   // Registered state.
    hfbt_cmd_state_t st_d;   // Next state.

    // The bit clears itself one cycle after it is set; a new set in that
    // same cycle wins over the clear so no command is lost.
    always_comb begin
        st_d.busy  = set_i;
        st_d.pulse = set_i;
    end

    // Register the state.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign bit_o   = st_q.busy;
    assign pulse_o = st_q.pulse;

endmodule // hfbt_cmd_bit

`default_nettype wire

// file: hw/hfbt_regs.sv
// Tuning register bank for the magnetic plates, freewheel scroll and touch
// button. Assumes an internal register port driven by the host interface
// engine, one access per cycle, index-addressed 16-bit words.
`default_nettype none

module hfbt_regs
    import hfbt_pkg::*;
(
    // ----------------------------------------------------------------
    // Clock and reset
    // ----------------------------------------------------------------
    input  wire logic         clk_sys_i,   // System clock, 25 MHz.
    input  wire logic         rstn_i,      // Asynchronous reset, active low.

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    input  wire logic         wr_en_i,     // Write strobe.
    input  wire logic         rd_en_i,     // Read strobe.
    input  wire logic [7:0]   addr_i,      // Register index.
    input  wire logic [15:0]  wdata_i,     // Write data.
    output logic      [15:0]  rdata_o,     // Read data, registered.
    output logic              rvalid_o,    // Read data valid, one cycle.
    output logic              addr_err_o,  // Access hit no register, one cycle.

    // ----------------------------------------------------------------
    // Magnetic plate settings
    // ----------------------------------------------------------------
    output logic      [7:0]   plate_first_a_bias_o,     // First plate A bias.
    output logic      [7:0]   plate_second_b_bias_o,    // Second plate B bias.
    output logic      [7:0]   plate_second_a_bias_o,    // Second plate A bias.
    output logic      [7:0]   plate_first_b_bias_o,     // First plate B bias.
    output logic      [7:0]   plate_first_a_offset_o,   // First plate A offset.
    output logic      [7:0]   plate_second_b_offset_o,  // Second plate B offset.
    output logic      [7:0]   plate_second_a_offset_o,  // Second plate A offset.
    output logic      [7:0]   plate_first_b_offset_o,   // First plate B offset.
    output logic      [7:0]   mag_auto_tuning_band_o,   // Magnetic band fraction.

    // ----------------------------------------------------------------
    // Freewheel scroll settings
    // ----------------------------------------------------------------
    output logic      [7:0]   scroll_follow_coeff_o,    // Follow coefficient.
    output logic      [7:0]   scroll_decay_coeff_o,     // Decay coefficient.
    output logic      [7:0]   scroll_fwd_release_thr_o, // Forward release level.
    output logic      [7:0]   scroll_stop_touch_thr_o,  // Stop touch level.
    output logic      [7:0]   scroll_rev_release_thr_o, // Reverse release level.

    // ----------------------------------------------------------------
    // Touch button settings
    // ----------------------------------------------------------------
    output logic      [7:0]   touch_lp_coeff_o,         // Low power coefficient.
    output logic      [7:0]   touch_np_coeff_o,         // Normal power coeff.
    output logic      [7:0]   touch_lp_long_term_average_o,  // Slow average, low.
    output logic      [7:0]   touch_np_long_term_average_o,  // Slow average, normal.
    output logic      [7:0]   touch_lp_fast_average_o,  // Fast average, low.
    output logic      [7:0]   touch_np_fast_average_o,  // Fast average, normal.
    output logic      [6:0]   touch_auto_tuning_band_o, // Touch band fraction.
    output logic      [7:0]   touch_fast_bound_o,       // Fast bound.
    output logic              touch_reseed_o            // Reseed pulse.
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------

    // Compare a register index against one bank slot. Shared by the write
    // strobes and the read multiplexer so both always agree.
    function automatic logic hfbt_hit(input logic [7:0] a, input int idx);
        logic r;
        r = (a == HFBT_OFS[idx]);
        return r;
    endfunction

    // True when an index names any register of the bank.
    function automatic logic hfbt_mapped(input logic [7:0] a);
        logic m;
        m = 1'b0;
        for (int k = 0; k < HFBT_NREG; k++) begin
            if (hfbt_hit(a, k)) begin
                m = 1'b1;
            end
        end
        return m;
    endfunction

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [15:0] reg_val [HFBT_NREG];   // Stored word of each slot.
    logic        reseed_bit;            // Reseed bit as read back.
    logic        reseed_pulse;          // Reseed pulse to the touch engine.
    logic        reseed_set;            // Write of one to the reseed bit.

    // One word per slot. The mask table keeps reserved bits at their reset
    // values, so a careless full-word write cannot disturb them.
    for (genvar g = 0; g < HFBT_NREG; g++) begin : g_reg
        logic wr_hit;   // Write strobe decoded for this slot.

        assign wr_hit = wr_en_i && hfbt_hit(addr_i, g);

        hfbt_field_reg #(
            .RST_VAL (HFBT_RST[g]),
            .WR_MASK (HFBT_WM[g])
        ) u_word (
            .clk_sys_i (clk_sys_i),
            .rstn_i    (rstn_i),
            .wr_i      (wr_hit),
            .wdata_i   (wdata_i),
            .q_o       (reg_val[g])
        );
    end

    // ----------------------------------------------------------------
    // Reseed command
    // ----------------------------------------------------------------

    // reseed on one
    // Only a written one starts a reseed; a written zero does nothing.
    assign reseed_set = wr_en_i
                        && hfbt_hit(addr_i, HFBT_IDX_RESEED)
                        && wdata_i[HFBT_RESEED_BIT];

    hfbt_cmd_bit u_reseed (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .set_i     (reseed_set),
        .bit_o     (reseed_bit),
        .pulse_o   (reseed_pulse)
    );

    // ----------------------------------------------------------------
    // Read port state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] rdata;    // Captured read word.
        logic        rvalid;   // Read answer strobe.
        logic        err;      // Unmapped access strobe.
    } hfbt_rd_state_t;

    hfbt_rd_state_t st_q;   // Registered state.
    hfbt_rd_state_t st_d;   // Next state.

    // Build the next read answer. An unmapped read returns zero and raises
    // the error strobe; an unmapped write is dropped and does the same.
    // The read sees the word as it stands before a same-cycle write.
    always_comb begin
        logic [15:0] word;   // Selected word.
        word     = '0;
        st_d     = st_q;
        st_d.rvalid = rd_en_i;
        st_d.err    = (rd_en_i || wr_en_i) && !hfbt_mapped(addr_i);
        for (int k = 0; k < HFBT_NREG; k++) begin
            if (hfbt_hit(addr_i, k)) begin
                word = reg_val[k];
            end
        end
        if (hfbt_hit(addr_i, HFBT_IDX_RESEED)) begin
            word[HFBT_RESEED_BIT] = reseed_bit;
        end
        if (rd_en_i) begin
            st_d.rdata = word;
        end
    end

    // Register the read port.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_o    = st_q.rdata;
    assign rvalid_o   = st_q.rvalid;
    assign addr_err_o = st_q.err;

    // ----------------------------------------------------------------
    // Magnetic plate fields
    // ----------------------------------------------------------------

    // bias pairs
    // The host is expected to keep these at reset; the bank still lets
    // them be written so a bench can trim a part if it must.
    // default recommended
    assign plate_second_b_bias_o = reg_val[0][HFBT_HI_LSB +: HFBT_BYTE_W];
    assign plate_first_a_bias_o  = reg_val[0][HFBT_LO_LSB +: HFBT_BYTE_W];
    assign plate_first_b_bias_o  = reg_val[1][HFBT_HI_LSB +: HFBT_BYTE_W];
    assign plate_second_a_bias_o = reg_val[1][HFBT_LO_LSB +: HFBT_BYTE_W];

    // offset pairs
    // Offsets have no defined default; they come up as zero here.
    assign plate_second_b_offset_o = reg_val[2][HFBT_HI_LSB +: HFBT_BYTE_W];
    assign plate_first_a_offset_o  = reg_val[2][HFBT_LO_LSB +: HFBT_BYTE_W];
    assign plate_first_b_offset_o  = reg_val[3][HFBT_HI_LSB +: HFBT_BYTE_W];
    assign plate_second_a_offset_o = reg_val[3][HFBT_LO_LSB +: HFBT_BYTE_W];

    // band fraction
    // The upper byte is reserved and reads back its fixed reset content.
    assign mag_auto_tuning_band_o = reg_val[7][HFBT_LO_LSB +: HFBT_BYTE_W];

    // ----------------------------------------------------------------
    // Freewheel scroll fields
    // ----------------------------------------------------------------

    assign scroll_follow_coeff_o = reg_val[4][HFBT_HI_LSB +: HFBT_BYTE_W];
    assign scroll_decay_coeff_o  = reg_val[4][HFBT_LO_LSB +: HFBT_BYTE_W];

    assign scroll_fwd_release_thr_o = reg_val[5][HFBT_HI_LSB +: HFBT_BYTE_W];
    assign scroll_stop_touch_thr_o  = reg_val[5][HFBT_LO_LSB +: HFBT_BYTE_W];

    assign scroll_rev_release_thr_o = reg_val[6][HFBT_LO_LSB +: HFBT_BYTE_W];

    // ----------------------------------------------------------------
    // Touch button fields
    // ----------------------------------------------------------------

    assign touch_lp_coeff_o = reg_val[8][HFBT_HI_LSB +: HFBT_BYTE_W];
    assign touch_np_coeff_o = reg_val[8][HFBT_LO_LSB +: HFBT_BYTE_W];

    assign touch_lp_long_term_average_o = reg_val[9][HFBT_HI_LSB +: HFBT_BYTE_W];
    assign touch_np_long_term_average_o = reg_val[9][HFBT_LO_LSB +: HFBT_BYTE_W];

    assign touch_lp_fast_average_o = reg_val[10][HFBT_HI_LSB +: HFBT_BYTE_W];
    assign touch_np_fast_average_o = reg_val[10][HFBT_LO_LSB +: HFBT_BYTE_W];

    assign touch_auto_tuning_band_o =
        reg_val[HFBT_IDX_RESEED][HFBT_BAND_LSB +: HFBT_BAND_W];
    assign touch_fast_bound_o =
        reg_val[HFBT_IDX_RESEED][HFBT_LO_LSB +: HFBT_BYTE_W];

    // The pulse is a flop inside the command bit, one cycle after the write.
    assign touch_reseed_o = reseed_pulse;

endmodule // hfbt_regs

`default_nettype wire

// file: bench/hfbt_regs_properties.sv
// Port checker for the tuning register bank.
// Assumes it is bound into hfbt_regs and sees only that module's ports.
`default_nettype none

module hfbt_regs_properties
    import hfbt_pkg::*;
(
    input wire logic        clk_sys_i,                 // System clock.
    input wire logic        rstn_i,                    // Reset, active low.
    input wire logic        wr_en_i,                   // Write strobe.
    input wire logic        rd_en_i,                   // Read strobe.
    input wire logic [7:0]  addr_i,                    // Register index.
    input wire logic [15:0] wdata_i,                   // Write data.
    input wire logic [15:0] rdata_o,                   // Read data.
    input wire logic        rvalid_o,                  // Read answer.
    input wire logic        addr_err_o,                // Unmapped access.
    input wire logic        touch_reseed_o,            // Reseed pulse.
    input wire logic [6:0]  touch_auto_tuning_band_o,  // Touch band.
    input wire logic [7:0]  touch_fast_bound_o,        // Fast bound.
    input wire logic [7:0]  scroll_rev_release_thr_o,  // Reverse level.
    input wire logic [7:0]  mag_auto_tuning_band_o,    // Magnetic band.
    input wire logic [7:0]  scroll_follow_coeff_o      // Follow coefficient.
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    logic        hit;   // Index names a register of the bank.
    logic        rsd;   // Write that asks for a reseed.
    logic [15:0] wd_q;  // Write data of the previous edge.
    assign hit = addr_i inside {HFBT_OFS};
    assign rsd = wr_en_i && addr_i == HFBT_OFS_TOUCH_RESEED && wdata_i[8];
    // The data register avoids slicing a sampled-value call.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wd_q <= 16'h0000;
        end else begin
            wd_q <= wdata_i;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_rd_answer; rd_en_i && hit |=> rvalid_o && !addr_err_o; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_bad_addr; (rd_en_i || wr_en_i) && !hit |=>
        addr_err_o && rvalid_o == $past(rd_en_i); endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped not flagged");
    property p_rdata_hold; !rd_en_i |=> $stable(rdata_o); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_reseed_fire; rsd |=> touch_reseed_o; endproperty
    a_reseed_fire: assert property (p_reseed_fire) else $error("reseed missed");
    property p_reseed_quiet; !rsd |=> !touch_reseed_o; endproperty
    a_reseed_quiet: assert property (p_reseed_quiet) else $error("stray reseed");
    property p_touch_fields;
        wr_en_i && addr_i == HFBT_OFS_TOUCH_RESEED |=>
            touch_auto_tuning_band_o == wd_q[15:9] && touch_fast_bound_o == wd_q[7:0];
    endproperty
    a_touch_fields: assert property (p_touch_fields) else $error("touch fields wrong");
    property p_rev_thr;
        wr_en_i && addr_i == HFBT_OFS_SCROLL_REV_THR |=> scroll_rev_release_thr_o == wd_q[7:0];
    endproperty
    a_rev_thr: assert property (p_rev_thr) else $error("reverse level wrong");
    property p_mag;
        wr_en_i && addr_i == HFBT_OFS_MAG_TUNING |=> mag_auto_tuning_band_o == wd_q[7:0];
    endproperty
    a_mag: assert property (p_mag) else $error("magnetic band wrong");
    property p_rsv_rd;
        rd_en_i && addr_i == HFBT_OFS_SCROLL_REV_THR |=> rdata_o[15:8] == 8'h00;
    endproperty
    a_rsv_rd: assert property (p_rsv_rd) else $error("reserved byte not zero");
    property p_coef_hold;
        !(wr_en_i && addr_i == HFBT_OFS_SCROLL_COEFFS) |=> $stable(scroll_follow_coeff_o);
    endproperty
    a_coef_hold: assert property (p_coef_hold) else $error("follow moved");
    c_reseed: cover property (rsd ##1 touch_reseed_o);
    c_bad: cover property (addr_err_o);
    c_read: cover property (rd_en_i ##1 rvalid_o);
endmodule // hfbt_regs_properties

bind hfbt_regs hfbt_regs_properties i_chk (.*);

`default_nettype wire

// file: bench/hfbt_regs_bench.sv
// Self-checking bench for the tuning register bank.
// Assumes the bank answers one cycle after each strobe.
`default_nettype none

module hfbt_regs_bench;
    import hfbt_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk_sys_i, rstn_i, wr_en_i, rd_en_i;  // Clock, reset, strobes.
    logic [7:0] addr_i;                          // Register index.
    logic [15:0] wdata_i, rdata_o;               // Data both ways.
    logic rvalid_o, addr_err_o, touch_reseed_o;  // Answer pulses.
    logic [7:0] fa, sb, fol, dec, fwd, stp, rev, mag, fast, px [12];  // Field outputs.
    logic [6:0] band;                            // Touch band fraction.
    int failures, n_tests, cyc;                  // Counters.

    hfbt_regs i_dut (.clk_sys_i, .rstn_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i,
        .rdata_o, .rvalid_o, .addr_err_o, .plate_first_a_bias_o(fa),
        .plate_second_b_bias_o(sb), .plate_second_a_bias_o(px[1]), .plate_first_b_bias_o(px[0]),
        .plate_first_a_offset_o(px[3]), .plate_second_b_offset_o(px[2]),
        .plate_second_a_offset_o(px[5]), .plate_first_b_offset_o(px[4]),
        .mag_auto_tuning_band_o(mag), .scroll_follow_coeff_o(fol),
        .scroll_decay_coeff_o(dec), .scroll_fwd_release_thr_o(fwd),
        .scroll_stop_touch_thr_o(stp), .scroll_rev_release_thr_o(rev), .touch_lp_coeff_o(px[6]),
        .touch_np_coeff_o(px[7]), .touch_lp_long_term_average_o(px[8]),
        .touch_np_long_term_average_o(px[9]), .touch_lp_fast_average_o(px[10]),
        .touch_np_fast_average_o(px[11]), .touch_auto_tuning_band_o(band),
        .touch_fast_bound_o(fast), .touch_reseed_o);

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Compares one value; case inequality keeps unknowns from matching.
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One access driven at a falling edge; returns at the next falling edge,
    // where the one-cycle answer stands. Strobes stay up for back-to-back use.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        wr_en_i = w;
        rd_en_i = !w;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        xfer(1'b0, a, 16'h0000);
        chk("rvalid", 16'h0001, {15'h0, rvalid_o});
        chk("rdata", e, rdata_o);
    endtask
    task automatic idle();
        wr_en_i = 1'b0;
        rd_en_i = 1'b0;
        @(negedge clk_sys_i);
    endtask
    // Reset is held four cycles, then every word must read its default.
    task automatic reset_and_check();
        rstn_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        for (int i = 0; i < HFBT_NREG; i++) rd(HFBT_OFS[i], HFBT_RST[i]);
        idle();
    endtask
    function automatic logic [15:0] pat(input int i);
        return {8'(i + 1), 8'(8'hf0 - i)};
    endfunction
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock and hang guard
    // ----------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // The run needs about 70 cycles; a stall past 5000 counts as a mismatch.
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {wr_en_i, rd_en_i, addr_i, wdata_i} = '0;
        rstn_i = 1'b0;
        @(negedge clk_sys_i);
        reset_and_check();
        // Back-to-back writes of every word, then read back through the masks.
        for (int i = 0; i < HFBT_NREG; i++) xfer(1'b1, HFBT_OFS[i], pat(i));
        idle();
        for (int i = 0; i < HFBT_NREG; i++)
            rd(HFBT_OFS[i], (pat(i) & HFBT_WM[i]) | (HFBT_RST[i] & ~HFBT_WM[i]));
        chk("bias", 16'h01f0, {sb, fa});
        chk("scroll_coef", 16'h05ec, {fol, dec});
        chk("scroll_thr", 16'h06eb, {fwd, stp});
        chk("rev_thr", 16'h00ea, {8'h00, rev});
        chk("mag_band", 16'h00e9, {8'h00, mag});
        chk("touch", 16'h06e5, {1'b0, band, fast});
        for (int i = 0; i < 6; i++)
            chk("px", pat(i + 1 + i / 3 * 4), {px[2*i], px[2*i+1]});
        // Unmapped write and read are flagged; the read still answers.
        xfer(1'b1, 8'h86, 16'hffff);
        chk("wr_err", 16'h0001, {15'h0, addr_err_o});
        xfer(1'b0, 8'h00, 16'h0000);
        chk("rd_err", 16'h0001, {15'h0, addr_err_o});
        chk("rd_valid", 16'h0001, {15'h0, rvalid_o});
        // Reseed: pulse and bit visible one cycle, then cleared.
        xfer(1'b1, HFBT_OFS_TOUCH_RESEED, 16'h1105);
        chk("reseed", 16'h0001, {15'h0, touch_reseed_o});
        rd(HFBT_OFS_TOUCH_RESEED, 16'h1105);
        chk("reseed_end", 16'h0000, {15'h0, touch_reseed_o});
        rd(HFBT_OFS_TOUCH_RESEED, 16'h1005);
        xfer(1'b1, HFBT_OFS_TOUCH_RESEED, 16'h1005);
        chk("reseed_zero", 16'h0000, {15'h0, touch_reseed_o});
        idle();
        reset_and_check();
        final_report();
    end
endmodule // hfbt_regs_bench

`default_nettype wire
